//--- core/lcr_bus_emul.sv
// emulated internal shared bus: resolves drivers by their enables
// assumes drivers and enables come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module lcr_bus_emul #(
  parameter int N = 4,
  parameter int W = 8
) (
  input wire logic [N*W-1:0] drv_data_in,
  input wire logic [N-1:0] drv_oe_in,
  output logic [W-1:0] value_out,
  output logic contention_out,
  output logic float_out
);

  // ****************************************************************
  // selector in place of a floating wire
  // ****************************************************************
  logic [W-1:0] pick; // data of the last enabled driver
  logic [1:0] hits; // saturating count of enabled drivers

  // scan the enables and pick the data of an enabled driver
  always_comb begin
    pick = '0;
    hits = 2'h0;
    for (int i = 0; i < N; i++) begin
      if (drv_oe_in[i]) begin
        pick = drv_data_in[i*W +: W];
        if (hits != 2'h2) begin
          hits = hits + 2'h1;
        end
      end
    end
  end

  assign contention_out = (hits == 2'h2);
  assign float_out = (hits == 2'h0);

  // contention resolves low, float resolves high, else the driver
  always_comb begin
    if (contention_out) begin
      value_out = '0;
    end else if (float_out) begin
      value_out = '1;
    end else begin
      value_out = pick;
    end
  end

endmodule
`default_nettype wire

//--- core/lcr_cell_top.sv
// logic cell register control: counter chain, async control options,
// emulated shared bus, dedicated input routing, AXI4-Lite registers
// assumes block control lines come from fabric logic on clk_sys_in;
// dedicated inputs are pins and are synchronised here
`timescale 1ns/1ps
`default_nettype none
module lcr_cell_top #(
  parameter int W = lcr_pkg::CELL_W,
  parameter int NB = lcr_pkg::BUS_DRV,
  parameter int ND = lcr_pkg::NUM_DED
) (
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic [3:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [3:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic block_control_first_in,
  input wire logic block_control_second_in,
  input wire logic [W-1:0] fourth_data_input_in,
  input wire logic sync_load_in,
  input wire logic [W-1:0] load_value_in,
  input wire logic cascade_clear_in,
  input wire logic [ND-1:0] dedicated_in,
  input wire logic [(NB-1)*W-1:0] bus_drv_data_in,
  input wire logic [NB-2:0] bus_drv_oe_in,
  output logic [W-1:0] cell_q_out,
  output logic carry_out,
  output logic [W-1:0] bus_value_out
);

  // ****************************************************************
  // helper functions
  // ****************************************************************
  // three-input lookup table
  function automatic logic lut3(input logic [7:0] tt, input logic a,
                                input logic b, input logic c);
    lut3 = tt[{c, b, a}];
  endfunction

  // pick one dedicated input by a routing field; off when disabled
  function automatic logic ded_pick(input logic [ND-1:0] v,
                                    input logic [3:0] fld);
    ded_pick = 1'b0;
    if (fld[lcr_pkg::DED_EN_OFS]) begin
      for (int i = 0; i < ND; i++) begin
        if (fld[2:0] == 3'(i)) begin
          ded_pick = v[i];
        end
      end
    end
  endfunction

  // merge write data into a register under byte strobes
  function automatic logic [31:0] strb_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0] st);
    strb_merge = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        strb_merge[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
  endfunction

  // ****************************************************************
  // registers and bus slave state
  // ****************************************************************
  logic [31:0] cfg_r; // async option, counter mode, preset style
  logic [31:0] ded_r; // dedicated input routing
  logic [3:0] awaddr_r; // latched write address
  logic aw_full_r; // write address held
  logic [31:0] wdata_r; // latched write data
  logic [3:0] wstrb_r; // latched write strobes
  logic w_full_r; // write data held
  logic bvalid_r; // write response pending
  logic [1:0] bresp_r; // write response code
  logic rvalid_r; // read data pending
  logic [31:0] rdata_r; // read data
  logic [1:0] rresp_r; // read response code
  logic [31:0] cfg_nxt; // cfg after a strobed write
  logic [31:0] ded_nxt; // ded after a strobed write
  logic wr_go; // both halves of a write held

  // ****************************************************************
  // cell state
  // ****************************************************************
  logic [ND-1:0] ded_s1_r; // first synchroniser stage
  logic [ND-1:0] ded_s2_r; // synchronised dedicated inputs
  logic [W-1:0] st_r; // stored value, inverted when inv is set
  logic [W-1:0] st_nxt; // next stored value
  logic [W-1:0] bus_r; // registered bus value
  logic bus_cont_r; // registered contention flag
  logic bus_float_r; // registered float flag
  lcr_pkg::lcr_amode_t mode; // current async option
  logic cnt_mode; // clearable counter mode
  logic pvc; // preset through inverted clear path
  logic inv; // register input and output inverted
  logic g_clr; // global clear from a dedicated input
  logic g_pre; // global preset from a dedicated input
  logic ce; // count enable
  logic oe0; // enable of this cell onto the bus
  logic c1; // first block control line
  logic c2; // second block control line
  logic [W-1:0] d3; // fourth data input as seen by the register
  logic [W-1:0] clr_n; // active-low clear per bit
  logic [W-1:0] pre_n; // active-low preset per bit
  logic [W-1:0] eff; // stored value after async overrides
  logic [W-1:0] q_vis; // visible value of the clocked register
  logic [W:0] cy; // fast carry chain
  logic [W-1:0] sum; // counter data from the sum tables
  logic [W-1:0] fab_nxt; // next visible value from sync logic
  logic [W-1:0] bus_val; // resolved bus value
  logic bus_cont; // contention now
  logic bus_float; // float now

  assign mode = lcr_pkg::lcr_amode_t'(cfg_r[lcr_pkg::CFG_MODE_LSB +: 3]);
  assign cnt_mode = cfg_r[lcr_pkg::CFG_CNT_BIT];
  assign pvc = cfg_r[lcr_pkg::CFG_PVC_BIT];
  assign c1 = block_control_first_in;
  assign c2 = block_control_second_in;

  // ****************************************************************
  // dedicated inputs
  // ****************************************************************
  // two-flop synchroniser for the dedicated pins
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      ded_s1_r <= '0;
      ded_s2_r <= '0;
    end else begin
      ded_s1_r <= dedicated_in;
      ded_s2_r <= ded_s1_r;
    end
  end

  // route a selected dedicated input to each control role
  always_comb begin
    g_clr = ded_pick(ded_s2_r, ded_r[lcr_pkg::DED_CLR_LSB +: 4]);
    g_pre = ded_pick(ded_s2_r, ded_r[lcr_pkg::DED_PRE_LSB +: 4]);
    ce = ded_r[lcr_pkg::DED_CE_LSB + lcr_pkg::DED_EN_OFS] ?
         ded_pick(ded_s2_r, ded_r[lcr_pkg::DED_CE_LSB +: 4]) : 1'b1;
    oe0 = ded_r[lcr_pkg::DED_OE_LSB + lcr_pkg::DED_EN_OFS] ?
          ded_pick(ded_s2_r, ded_r[lcr_pkg::DED_OE_LSB +: 4]) : 1'b1;
  end

  // ****************************************************************
  // asynchronous clear, preset and load
  // ****************************************************************
  // active-low controls per option; unused ones held high
  always_comb begin
    inv = (mode == lcr_pkg::AM_LDPRE) ||
          ((mode == lcr_pkg::AM_PRE) && pvc);
    d3 = fourth_data_input_in;
    clr_n = '1;
    pre_n = '1;
    case (mode)
      lcr_pkg::AM_CLR: begin
        clr_n = ~{W{c1 | c2}};
      end
      lcr_pkg::AM_PRE: begin
        if (pvc) begin
          clr_n = ~{W{c1}};
        end else begin
          d3 = '1;
          pre_n = ~({W{c1}} & d3);
        end
      end
      lcr_pkg::AM_CLRPRE: begin
        d3 = '1;
        pre_n = ~({W{c1}} & d3);
        clr_n = ~{W{c2}};
      end
      lcr_pkg::AM_LDCLR: begin
        pre_n = ~({W{c1}} & d3);
        clr_n = ~(({W{c1}} & ~d3) | {W{c2}});
      end
      lcr_pkg::AM_LDPRE: begin
        d3 = ~fourth_data_input_in;
        pre_n = ~({W{c1}} & d3);
        clr_n = ~(({W{c1}} & ~d3) | {W{c2}});
      end
      lcr_pkg::AM_LD: begin
        pre_n = ~({W{c1}} & d3);
        clr_n = ~({W{c1}} & ~d3);
      end
      default: begin
        clr_n = '1;
        pre_n = '1;
      end
    endcase
    // global controls act on the visible value
    if (inv ? g_pre : g_clr) begin
      clr_n = '0;
    end
    if (inv ? g_clr : g_pre) begin
      pre_n = '0;
    end
    eff = (st_r | ~pre_n) & clr_n; // clear wins over preset
  end

  // overrides show at the output without waiting for an edge
  assign cell_q_out = eff ^ {W{inv}};
  assign q_vis = st_r ^ {W{inv}};

  // ****************************************************************
  // clearable counter chain
  // ****************************************************************
  always_comb begin
    cy[0] = 1'b1; // carry into the lowest cell: count by one
    for (int i = 0; i < W; i++) begin
      sum[i] = lut3(lcr_pkg::LUT_SUM_TT, q_vis[i], cy[i], ce);
      cy[i+1] = lut3(lcr_pkg::LUT_CARRY_TT, q_vis[i], cy[i], ce);
    end
  end
  assign carry_out = cy[W];

  // load/count selector gated by the synchronous clear
  always_comb begin
    fab_nxt = sync_load_in ? load_value_in : (cnt_mode ? sum : q_vis);
    fab_nxt = fab_nxt & {W{~cascade_clear_in}};
    st_nxt = ((~clr_n | ~pre_n) & eff) |
             ((clr_n & pre_n) & (fab_nxt ^ {W{inv}}));
  end

  // the cell register
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // emulated shared bus
  // ****************************************************************
  lcr_bus_emul #(.N(NB), .W(W)) u_bus (
    .drv_data_in({bus_drv_data_in, cell_q_out}),
    .drv_oe_in({bus_drv_oe_in, oe0}),
    .value_out(bus_val),
    .contention_out(bus_cont),
    .float_out(bus_float)
  );

  // register the resolved bus
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      bus_r <= '1;
      bus_cont_r <= 1'b0;
      bus_float_r <= 1'b1;
    end else begin
      bus_r <= bus_val;
      bus_cont_r <= bus_cont;
      bus_float_r <= bus_float;
    end
  end
  assign bus_value_out = bus_r;

  // ****************************************************************
  // AXI4-Lite write channel
  // ****************************************************************
  assign s_axi_awready_out = !aw_full_r && !bvalid_r;
  assign s_axi_wready_out = !w_full_r && !bvalid_r;
  assign wr_go = aw_full_r && w_full_r && !bvalid_r;
  assign cfg_nxt = strb_merge(cfg_r, wdata_r, wstrb_r);
  assign ded_nxt = strb_merge(ded_r, wdata_r, wstrb_r);

  // hold address and data until both are in, then answer
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      awaddr_r <= 4'h0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= lcr_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_full_r <= 1'b1;
        awaddr_r <= s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_full_r <= 1'b1;
        wdata_r <= s_axi_wdata_in;
        wstrb_r <= s_axi_wstrb_in;
      end
      if (wr_go) begin
        aw_full_r <= 1'b0;
        w_full_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= (awaddr_r == lcr_pkg::ADDR_CFG ||
                    awaddr_r == lcr_pkg::ADDR_DED ||
                    awaddr_r == lcr_pkg::ADDR_STAT ||
                    awaddr_r == lcr_pkg::ADDR_BUS) ?
                   lcr_pkg::RESP_OKAY : lcr_pkg::RESP_DECERR;
      end else if (bvalid_r && s_axi_bready_in) begin
        bvalid_r <= 1'b0;
      end
    end
  end
  assign s_axi_bvalid_out = bvalid_r;
  assign s_axi_bresp_out = bresp_r;

  // configuration registers; an undefined option leaves the mode as is
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      cfg_r <= lcr_pkg::CFG_RST;
      ded_r <= lcr_pkg::DED_RST;
    end else if (wr_go) begin
      if (awaddr_r == lcr_pkg::ADDR_CFG) begin
        cfg_r[4:3] <= cfg_nxt[4:3];
        if (cfg_nxt[2:0] <= 3'(lcr_pkg::AM_LD)) begin
          cfg_r[2:0] <= cfg_nxt[2:0];
        end
      end
      if (awaddr_r == lcr_pkg::ADDR_DED) begin
        ded_r[15:0] <= ded_nxt[15:0]; // only four routing fields exist
      end
    end
  end

  // ****************************************************************
  // AXI4-Lite read channel
  // ****************************************************************
  assign s_axi_arready_out = !rvalid_r;

  // one-cycle read answer with state of the cell
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= lcr_pkg::RESP_OKAY;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      rvalid_r <= 1'b1;
      rresp_r <= lcr_pkg::RESP_OKAY;
      rdata_r <= 32'h0000_0000;
      case (s_axi_araddr_in)
        lcr_pkg::ADDR_CFG: rdata_r <= {27'h0, cfg_r[4:0]};
        lcr_pkg::ADDR_DED: rdata_r <= {16'h0, ded_r[15:0]};
        lcr_pkg::ADDR_STAT: begin
          rdata_r[W-1:0] <= cell_q_out;
          rdata_r[lcr_pkg::STAT_DED_LSB +: ND] <= ded_s2_r;
          rdata_r[lcr_pkg::STAT_CARRY_BIT] <= carry_out;
        end
        lcr_pkg::ADDR_BUS: begin
          rdata_r[W-1:0] <= bus_r;
          rdata_r[lcr_pkg::BUS_CONT_BIT] <= bus_cont_r;
          rdata_r[lcr_pkg::BUS_FLOAT_BIT] <= bus_float_r;
        end
        default: rresp_r <= lcr_pkg::RESP_DECERR;
      endcase
    end else if (rvalid_r && s_axi_rready_in) begin
      rvalid_r <= 1'b0;
    end
  end
  assign s_axi_rvalid_out = rvalid_r;
  assign s_axi_rdata_out = rdata_r;
  assign s_axi_rresp_out = rresp_r;

  // ****************************************************************
  // assertions
  // ****************************************************************
  logic quiet; // no async override at all
  assign quiet = (&clr_n) && (&pre_n);

  sequence s_clean_count;
    cnt_mode && ce && quiet && !sync_load_in && !cascade_clear_in;
  endsequence

  sequence s_mode_kept;
    $stable(cfg_r[4:0]);
  endsequence

  chk_count_step: assert property (@(posedge clk_sys_in)
    disable iff (reset_in) s_clean_count ##1 s_mode_kept
    |-> q_vis == W'($past(q_vis) + 1'b1))
    else $error("counter did not step by one");

  chk_sync_clear: assert property (@(posedge clk_sys_in)
    disable iff (reset_in) (cascade_clear_in && quiet) ##1 s_mode_kept
    |-> q_vis == '0)
    else $error("sync clear did not force zero");

  chk_carry_chain: assert property (@(posedge clk_sys_in)
    disable iff (reset_in) carry_out == ((&q_vis) && ce))
    else $error("fast carry wrong");

  chk_clear_mode: assert property (@(posedge clk_sys_in)
    disable iff (reset_in) (mode == lcr_pkg::AM_CLR && (c1 || c2)
    && !g_pre) |-> cell_q_out == '0
    ##1 (!$stable(cfg_r[4:0]) || q_vis == '0))
    else $error("clear option did not clear");

  chk_preset_load: assert property (@(posedge clk_sys_in)
    disable iff (reset_in) (mode == lcr_pkg::AM_PRE && !pvc && c1
    && !g_clr) |-> cell_q_out == '1)
    else $error("preset did not load ones");

  chk_clr_pre_mode: assert property (@(posedge clk_sys_in)
    disable iff (reset_in) (mode == lcr_pkg::AM_CLRPRE && c2 && !g_pre)
    |-> cell_q_out == '0)
    else $error("second line did not clear");

  chk_load_clear: assert property (@(posedge clk_sys_in)
    disable iff (reset_in) (mode == lcr_pkg::AM_LDCLR && c1 && !c2
    && !g_clr && !g_pre) |-> cell_q_out == fourth_data_input_in)
    else $error("load with clear wrong");

  chk_load_preset: assert property (@(posedge clk_sys_in)
    disable iff (reset_in) (mode == lcr_pkg::AM_LDPRE && c2 && !g_clr)
    |-> cell_q_out == '1)
    else $error("second line did not preset");

  chk_load_only: assert property (@(posedge clk_sys_in)
    disable iff (reset_in) (mode == lcr_pkg::AM_LD && c1 && !g_clr
    && !g_pre) |-> cell_q_out == fourth_data_input_in)
    else $error("load only did not copy data");

  chk_bus_resolve: assert property (@(posedge clk_sys_in)
    disable iff (reset_in) ((bus_drv_oe_in == '0) && !oe0)
    |=> bus_value_out == '1 && bus_float_r)
    else $error("floating bus not high");

  chk_bus_contend: assert property (@(posedge clk_sys_in)
    disable iff (reset_in) (oe0 && (bus_drv_oe_in != '0))
    |=> bus_value_out == '0 && bus_cont_r)
    else $error("contended bus not low");

  chk_mode_legal: assert property (@(posedge clk_sys_in)
    disable iff (reset_in) cfg_r[2:0] <= 3'(lcr_pkg::AM_LD))
    else $error("illegal async option held");

endmodule
`default_nettype wire

//--- core/lcr_pkg.sv
// constants, types and field layout of the logic cell register control
// assumes a single 40 MHz system clock and an AXI4-Lite register bus
package lcr_pkg;

  // ****************************************************************
  // register map (byte addresses)
  // ****************************************************************
  localparam logic [3:0] ADDR_CFG = 4'h0; // configuration, read/write
  localparam logic [3:0] ADDR_DED = 4'h4; // dedicated input routing
  localparam logic [3:0] ADDR_STAT = 4'h8; // cell state, read only
  localparam logic [3:0] ADDR_BUS = 4'hc; // emulated bus, read only

  // ****************************************************************
  // field layout
  // ****************************************************************
  localparam int CFG_MODE_LSB = 0; // 3-bit async option
  localparam int CFG_CNT_BIT = 3; // clearable counter mode
  localparam int CFG_PVC_BIT = 4; // preset built from clear path
  localparam int DED_CLR_LSB = 0; // global clear select + enable
  localparam int DED_PRE_LSB = 4; // global preset select + enable
  localparam int DED_CE_LSB = 8; // count enable select + enable
  localparam int DED_OE_LSB = 12; // bus output enable select + enable
  localparam int DED_EN_OFS = 3; // enable bit inside each field
  localparam int STAT_DED_LSB = 16; // synchronised dedicated inputs
  localparam int STAT_CARRY_BIT = 24; // fast carry out of the chain
  localparam int BUS_CONT_BIT = 30; // more than one driver enabled
  localparam int BUS_FLOAT_BIT = 31; // no driver enabled

  // ****************************************************************
  // reset values and sizes
  // ****************************************************************
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic [31:0] DED_RST = 32'h0000_0000;
  localparam int NUM_DED = 6; // dedicated low-skew inputs
  localparam int CELL_W = 8; // cells in the counter chain
  localparam int BUS_DRV = 4; // drivers on the emulated bus

  // ****************************************************************
  // lookup table contents, index {enable, carry_in, q}
  // ****************************************************************
  localparam logic [7:0] LUT_SUM_TT = 8'h6a; // q xor (cin and en)
  localparam logic [7:0] LUT_CARRY_TT = 8'h80; // q and cin and en

  // ****************************************************************
  // bus responses
  // ****************************************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // asynchronous control options chosen through the configuration register
  typedef enum logic [2:0] {
    AM_CLR = 3'h0, // clear by either control line
    AM_PRE = 3'h1, // preset
    AM_CLRPRE = 3'h2, // clear and preset
    AM_LDCLR = 3'h3, // load with clear
    AM_LDPRE = 3'h4, // load with preset
    AM_LD = 3'h5 // load without clear or preset
  } lcr_amode_t;

endpackage

//--- test/lcr_cell_top_tb.sv
// bench: register bus master, fabric model, queued checks
// assumes lcr_pkg and the design are compiled first
`timescale 1ns/1ps
`default_nettype none
module lcr_cell_top_tb;
  logic clk = 0, rst = 1; // clock, sync reset
  logic [3:0] awaddr = 0, araddr = 0; // bus addresses
  logic awv = 0, wv = 0, arv = 0; // request valids
  logic bready = 1, rready = 1; // answers always accepted
  logic [31:0] wdata = 0, rdata; // bus data
  logic awrdy, wrdy, bv, arrdy, rv, carry;
  logic [1:0] bresp, rresp;
  logic f = 0, s = 0, sl = 0, sc = 0; // fabric commands
  logic [7:0] d4 = 0, lv = 0, q, bus, x;
  logic [2:0] oe = 0; // extra bus driver enables
  logic [23:0] bd = 0; // extra bus driver data
  logic [5:0] ded = 0; // dedicated pins
  logic [46:0] drv; // fabric model outputs
  logic [65:0] e; // popped read note
  logic [11:0] tbl [14] = '{12'h008, 12'h004, 12'h003, 12'h019,
    12'h119, 12'h029, 12'h024, 12'h02c, 12'h03a, 12'h034, 12'h04a,
    12'h045, 12'h05a, 12'h057}; // {cfg, first, second, result}
  int seed = 91735, miscompares = 0, check_count = 0, cyc = 0;
  logic [65:0] qr [$]; // read notes {resp, mask, data}
  logic [1:0] qb [$]; // write notes
  lcr_fabric_model i_lcr_fabric_model (.clk_in(clk),
    .cmd_in({f, s, sl, sc, d4, lv, oe, bd}), .drive_out(drv));
  lcr_cell_top i_lcr_cell_top (.clk_sys_in(clk), .reset_in(rst),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awv),
    .s_axi_awready_out(awrdy), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wv),
    .s_axi_wready_out(wrdy), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bv), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arv),
    .s_axi_arready_out(arrdy), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rv),
    .s_axi_rready_in(rready), .block_control_first_in(drv[46]),
    .block_control_second_in(drv[45]), .sync_load_in(drv[44]),
    .cascade_clear_in(drv[43]), .fourth_data_input_in(drv[42:35]),
    .load_value_in(drv[34:27]), .bus_drv_oe_in(drv[26:24]),
    .bus_drv_data_in(drv[23:0]), .dedicated_in(ded),
    .cell_q_out(q), .carry_out(carry), .bus_value_out(bus));
  // compare and count
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // one write, address and data offered together
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    qb.push_back(lcr_pkg::RESP_OKAY);
    awaddr <= a;
    wdata <= d;
    awv <= 1;
    wv <= 1;
    do begin
      @(posedge clk);
      if (awrdy) awv <= 0;
      if (wrdy) wv <= 0;
    end while (!bv);
  endtask
  // one read, expectation noted first
  task automatic rd(input logic [3:0] a, input logic [31:0] m,
                    input logic [31:0] d, input logic [1:0] r);
    qr.push_back({r, m, d});
    araddr <= a;
    arv <= 1;
    do begin
      @(posedge clk);
      if (arrdy) arv <= 0;
    end while (!rv);
  endtask
  task automatic complete_run;
    if (miscompares == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial forever #12.5 clk = ~clk;
  // monitor: each response takes the oldest note
  always @(posedge clk) begin
    if (bv && bready) chk({bresp, 32'h0}, {qb.pop_front(), 32'h0});
    if (rv && rready) begin
      e = qr.pop_front();
      chk({rresp, rdata & e[63:32]}, {e[65:64], e[31:0]});
    end
  end
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      complete_run();
    end
  end
  initial begin
    tick(20);
    rst <= 0;
    tick(1);
    rd(lcr_pkg::ADDR_CFG, '1, lcr_pkg::CFG_RST, 2'h0);
    rd(4'h2, '1, 32'h0, lcr_pkg::RESP_DECERR);
    // every async option with each control line it uses
    foreach (tbl[i]) begin
      wr(lcr_pkg::ADDR_CFG, {24'h0, tbl[i][11:4]});
      lv <= 8'($random(seed));
      d4 <= 8'($random(seed));
      sl <= 1;
      tick(2);
      sl <= 0;
      f <= tbl[i][3];
      s <= tbl[i][2];
      tick(2);
      x = tbl[i][1] ? (tbl[i][0] ? lv : d4) : {8{tbl[i][0]}};
      rd(lcr_pkg::ADDR_STAT, 32'hff, {24'h0, x}, 2'h0);
      f <= 0;
      s <= 0;
      tick(2);
    end
    wr(lcr_pkg::ADDR_CFG, 32'h6);
    rd(lcr_pkg::ADDR_CFG, 32'h1f, 32'h5, 2'h0);
    // counter: enable from pin 0, three counts wrap fe to 01
    wr(lcr_pkg::ADDR_DED, 32'h800);
    wr(lcr_pkg::ADDR_CFG, 32'h8);
    lv <= 8'hfe;
    sl <= 1;
    tick(2);
    sl <= 0;
    tick(2);
    rd(lcr_pkg::ADDR_STAT, 32'h010000ff, 32'hfe, 2'h0);
    ded <= 6'h1;
    tick(3);
    ded <= 0;
    tick(6);
    rd(lcr_pkg::ADDR_STAT, 32'h010000ff, 32'h01, 2'h0);
    sl <= 1;
    sc <= 1;
    tick(3);
    rd(lcr_pkg::ADDR_STAT, 32'hff, 32'h0, 2'h0);
    sc <= 0;
    // bus: contention, float, single driver
    wr(lcr_pkg::ADDR_CFG, 32'h0);
    bd <= 24'($random(seed));
    oe <= 3'h1;
    tick(4);
    rd(lcr_pkg::ADDR_BUS, 32'hc00000ff, 32'h40000000, 2'h0);
    oe <= 3'h0;
    wr(lcr_pkg::ADDR_DED, 32'h9000);
    tick(4);
    rd(lcr_pkg::ADDR_BUS, 32'hc00000ff, 32'h800000ff, 2'h0);
    oe <= 3'h4;
    tick(4);
    rd(lcr_pkg::ADDR_BUS, 32'hc00000ff, {24'h0, bd[23:16]}, 2'h0);
    // each dedicated pin as global clear
    lv <= 8'h5a;
    for (int k = 0; k < 6; k++) begin
      wr(lcr_pkg::ADDR_DED, {28'h0, 1'b1, 3'(k)});
      ded <= 6'(1 << k);
      tick(4);
      rd(lcr_pkg::ADDR_STAT, 32'h003f00ff, 32'h1 << (16 + k), 2'h0);
      ded <= 0;
    end
    complete_run();
  end
endmodule
`default_nettype wire

//--- test/lcr_fabric_model.sv
// fabric model: user logic driving the cell's control and bus lines
// assumes bench commands on the same clock; outputs are registered
`timescale 1ns/1ps
`default_nettype none
module lcr_fabric_model (
  input wire logic clk_in,
  input wire logic [46:0] cmd_in,
  output logic [46:0] drive_out
);
  // registered user logic: lines move just after each edge
  always_ff @(posedge clk_in) begin
    drive_out <= cmd_in;
  end
endmodule
`default_nettype wire
